// ---- src/ubm_uart_core.v ----
// serial transmit/receive buffers, shifters and operation mode control
`timescale 1ns/10ps

module ubm_uart_core #(
	parameter BASE_DIV  = 4,
	parameter BIT_TICKS = 16
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [15:0] addr,
	input  wire [7:0]  wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [7:0]  rdata_q,
	input  wire        serial_in_pin,
	output wire        serial_out_pin,
	output reg         transmit_complete_irq_q,
	output reg         receive_complete_irq_q,
	output reg         receive_error_irq_q
);
`include "ubm_defs.vh"

	localparam TX_IDLE = 3'h0;
	localparam TX_START = 3'h1;
	localparam TX_DATA = 3'h2;
	localparam TX_PAR = 3'h3;
	localparam TX_STOP = 3'h4;
	localparam RX_IDLE = 3'h0;
	localparam RX_START = 3'h1;
	localparam RX_DATA = 3'h2;
	localparam RX_PAR = 3'h3;
	localparam RX_STOP = 3'h4;
	localparam integer HALF_I = BIT_TICKS / 2;
	localparam integer LAST_I = BIT_TICKS - 1;
	localparam integer DLAST_I = BASE_DIV - 1;
	localparam [7:0] HALF = HALF_I[7:0];
	localparam [7:0] LAST = LAST_I[7:0];
	localparam [7:0] DLAST = DLAST_I[7:0];

	function hit;
		input [15:0] a;
		input [15:0] off;
		hit = (a == off);
	endfunction

	function par_of;
		input [7:0] d;
		input       msb;
		input       cl8;
		par_of = ^(d & (cl8 ? `UBM_RST_BUF : (msb ? `UBM_MASK_MSB7 : `UBM_MASK_LSB7)));
	endfunction

	reg  [7:0] mode_q;
	reg        msb_q;
	reg  [7:0] rxbuf_q;
	reg  [7:0] txbuf_q;
	reg  [2:0] err_q;
	reg        txbf_q;
	reg        rx_full_q;
	reg  [7:0] div_q;
	reg        base_q;
	reg        pwr_run_q;
	reg        tx_run_q;
	reg        rx_run_q;
	reg        tx_arm_q;
	reg        rx_arm_q;
	reg  [2:0] tx_st_q;
	reg  [7:0] tx_sh_q;
	reg  [7:0] tx_tk_q;
	reg  [3:0] tx_n_q;
	reg        tx_par_q;
	reg        tx_out_q;
	reg  [2:0] rx_st_q;
	reg  [7:0] rx_sh_q;
	reg  [7:0] rx_tk_q;
	reg  [3:0] rx_n_q;
	reg        rx_pe_q;

	wire       pwr = mode_q[`UBM_MODE_PWR];
	wire       txe = mode_q[`UBM_MODE_TXE];
	wire       rxe = mode_q[`UBM_MODE_RXE];
	wire [1:0] ps = {mode_q[`UBM_MODE_PS_HI], mode_q[`UBM_MODE_PS_LO]};
	wire       cl8 = mode_q[`UBM_MODE_CL];
	wire [3:0] nbits = cl8 ? 4'h8 : 4'h7;
	wire       fall = pwr_run_q && base_q && (div_q == DLAST);
	wire       rx_line = pwr ? serial_in_pin : 1'b1;
	wire       wr_tx = wr_en && hit(addr, `UBM_OFF_TXBUF);
	wire       rd_err = rd_en && hit(addr, `UBM_OFF_ERR);
	wire       rd_rx = rd_en && hit(addr, `UBM_OFF_RXBUF);
	wire       tx_bit_end = fall && (tx_tk_q == LAST);
	wire       tx_go = fall && txbf_q;
	wire       tx_last = tx_bit_end && (tx_st_q == TX_STOP) && (tx_n_q == 4'h0);
	wire       rx_done = fall && (rx_st_q == RX_STOP) && (rx_tk_q == LAST);
	wire [7:0] rx_data = (cl8 ? rx_sh_q : (msb_q ? {rx_sh_q[6:0], 1'b0} : {1'b0, rx_sh_q[7:1]}));
	wire       rx_perr = rx_pe_q && (ps[1] == 1'b1);
	wire       rx_ferr = !rx_line;
	wire       rx_ovr = rx_full_q && !rd_rx;

	assign serial_out_pin = tx_out_q;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `UBM_RST_MODE;
			msb_q <= 1'b0;
			txbuf_q <= `UBM_RST_BUF;
			rdata_q <= 8'h00;
		end else begin
			if (wr_en && hit(addr, `UBM_OFF_MODE))
				mode_q <= wdata;
			if (wr_en && hit(addr, `UBM_OFF_DIR))
				msb_q <= wdata[`UBM_DIR_MSB];
			if (wr_tx)
				txbuf_q <= wdata;
			rdata_q <= 8'h00;
			if (rd_en) begin
				if (hit(addr, `UBM_OFF_MODE))
					rdata_q <= mode_q;
				else if (hit(addr, `UBM_OFF_ERR))
					rdata_q <= {5'h00, err_q};
				else if (hit(addr, `UBM_OFF_RXBUF))
					rdata_q <= rxbuf_q;
				else if (hit(addr, `UBM_OFF_TXBUF))
					rdata_q <= txbuf_q;
				else if (hit(addr, `UBM_OFF_DIR))
					rdata_q <= {7'h00, msb_q};
				else if (hit(addr, `UBM_OFF_TXSTAT))
					rdata_q <= {6'h00, txbf_q, (tx_st_q != TX_IDLE)};
			end
		end
	end

	// ----------------------------------------
	// base clock and enable sequencing
	// ----------------------------------------
	// power-off reset is applied synchronously so no register bit drives a reset pin
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 8'h00;
			base_q <= 1'b0;
			pwr_run_q <= 1'b0;
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
			tx_arm_q <= 1'b0;
			rx_arm_q <= 1'b0;
		end else if (!pwr) begin
			div_q <= 8'h00;
			base_q <= 1'b0;
			pwr_run_q <= 1'b0;
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
			tx_arm_q <= 1'b0;
			rx_arm_q <= 1'b0;
		end else begin
			div_q <= (div_q == DLAST) ? 8'h00 : div_q + 8'h01;
			if (div_q == DLAST) begin
				base_q <= ~base_q;
				if (base_q)
					pwr_run_q <= 1'b1;
			end
			// first tick only arms: an enable set just before a tick still waits a whole base period
			tx_arm_q <= txe && (tx_arm_q || fall);
			rx_arm_q <= rxe && (rx_arm_q || fall);
			tx_run_q <= txe && (tx_run_q || (tx_arm_q && fall));
			rx_run_q <= rxe && (rx_run_q || (rx_arm_q && fall));
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txbf_q <= 1'b0;
			tx_st_q <= TX_IDLE;
			tx_sh_q <= 8'h00;
			tx_tk_q <= 8'h00;
			tx_n_q <= 4'h0;
			tx_par_q <= 1'b0;
			tx_out_q <= 1'b1;
			transmit_complete_irq_q <= 1'b0;
		end else if (!pwr || !tx_run_q) begin
			txbf_q <= 1'b0;
			tx_st_q <= TX_IDLE;
			tx_tk_q <= 8'h00;
			tx_out_q <= 1'b1;
			transmit_complete_irq_q <= 1'b0;
		end else begin
			transmit_complete_irq_q <= 1'b0;
			// write is flagged only when enabled; a write over a full buffer replaces the waiting character
			if (wr_tx)
				txbf_q <= 1'b1;
			if (fall)
				tx_tk_q <= (tx_tk_q == LAST) ? 8'h00 : tx_tk_q + 8'h01;
			case (tx_st_q)
				TX_IDLE: begin
					tx_out_q <= 1'b1;
					if (tx_go) begin
						tx_sh_q <= txbuf_q;
						tx_par_q <= par_of(txbuf_q, msb_q, cl8);
						txbf_q <= wr_tx;
						tx_tk_q <= 8'h00;
						tx_out_q <= 1'b0;
						tx_st_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_n_q <= nbits;
						tx_st_q <= TX_DATA;
						tx_out_q <= msb_q ? tx_sh_q[7] : tx_sh_q[0];
					end
				end
				TX_DATA: begin
					if (tx_bit_end) begin
						if (tx_n_q == 4'h1) begin
							tx_st_q <= (ps == `UBM_PAR_NONE) ? TX_STOP : TX_PAR;
							tx_n_q <= {3'h0, mode_q[`UBM_MODE_SL]};
							if (ps == `UBM_PAR_NONE)
								tx_out_q <= 1'b1;
							else if (ps == `UBM_PAR_ZERO)
								tx_out_q <= 1'b0;
							else
								tx_out_q <= tx_par_q ^ (ps == `UBM_PAR_ODD);
						end else begin
							tx_n_q <= tx_n_q - 4'h1;
							tx_out_q <= msb_q ? tx_sh_q[6] : tx_sh_q[1];
							tx_sh_q <= msb_q ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
						end
					end
				end
				TX_PAR: begin
					if (tx_bit_end) begin
						tx_out_q <= 1'b1;
						tx_st_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_last) begin
						transmit_complete_irq_q <= 1'b1;
						if (txbf_q) begin
							tx_sh_q <= txbuf_q;
							tx_par_q <= par_of(txbuf_q, msb_q, cl8);
							txbf_q <= wr_tx;
							tx_out_q <= 1'b0;
							tx_st_q <= TX_START;
						end else
							tx_st_q <= TX_IDLE;
					end else if (tx_bit_end)
						tx_n_q <= tx_n_q - 4'h1;
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxbuf_q <= `UBM_RST_BUF;
			rx_full_q <= 1'b0;
			err_q <= 3'h0;
			rx_st_q <= RX_IDLE;
			rx_sh_q <= 8'h00;
			rx_tk_q <= 8'h00;
			rx_n_q <= 4'h0;
			rx_pe_q <= 1'b0;
			receive_complete_irq_q <= 1'b0;
			receive_error_irq_q <= 1'b0;
		end else if (!pwr) begin
			rxbuf_q <= `UBM_RST_BUF;
			rx_full_q <= 1'b0;
			err_q <= 3'h0;
			rx_st_q <= RX_IDLE;
			receive_complete_irq_q <= 1'b0;
			receive_error_irq_q <= 1'b0;
		end else if (!rx_run_q) begin
			rx_st_q <= RX_IDLE;
			rx_full_q <= 1'b0;
			receive_complete_irq_q <= 1'b0;
			receive_error_irq_q <= 1'b0;
		end else begin
			receive_complete_irq_q <= 1'b0;
			receive_error_irq_q <= 1'b0;
			if (rd_rx)
				rx_full_q <= 1'b0;
			if (rd_err)
				err_q <= 3'h0;
			if (fall)
				rx_tk_q <= (rx_tk_q == LAST) ? 8'h00 : rx_tk_q + 8'h01;
			case (rx_st_q)
				RX_IDLE: begin
					rx_tk_q <= 8'h00;
					if (fall && !rx_line) begin
						rx_tk_q <= 8'h01;
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					// sampling mid-bit rejects glitches shorter than half a bit
					if (fall && rx_tk_q == HALF) begin
						rx_tk_q <= 8'h00;
						rx_sh_q <= 8'h00;
						rx_n_q <= nbits;
						rx_pe_q <= 1'b0;
						rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (fall && rx_tk_q == LAST) begin
						rx_sh_q <= msb_q ? {rx_sh_q[6:0], rx_line} : {rx_line, rx_sh_q[7:1]};
						rx_pe_q <= rx_pe_q ^ rx_line;
						rx_n_q <= rx_n_q - 4'h1;
						if (rx_n_q == 4'h1)
							rx_st_q <= (ps == `UBM_PAR_NONE) ? RX_STOP : RX_PAR;
					end
				end
				RX_PAR: begin
					if (fall && rx_tk_q == LAST) begin
						// zero parity is received but never judged
						rx_pe_q <= rx_pe_q ^ rx_line ^ (ps == `UBM_PAR_ODD);
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_done) begin
						rx_st_q <= RX_IDLE;
						if (rx_ovr)
							err_q[`UBM_ERR_OVE] <= 1'b1;
						else begin
							rxbuf_q <= rx_data;
							rx_full_q <= 1'b1;
						end
						if (rx_perr)
							err_q[`UBM_ERR_PE] <= 1'b1;
						if (rx_ferr)
							err_q[`UBM_ERR_FE] <= 1'b1;
						if ((rx_ovr || rx_perr || rx_ferr) && !mode_q[`UBM_MODE_ISRM])
							receive_error_irq_q <= 1'b1;
						else
							receive_complete_irq_q <= 1'b1;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

endmodule // ubm_uart_core

// ---- src/ubm_defs.vh ----
// register offsets, field positions and reset values of the serial buffers and mode block
`ifndef UBM_DEFS_VH
`define UBM_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UBM_ADDR_W      16
`define UBM_OFF_MODE    16'hFF90
`define UBM_OFF_ERR     16'hFF91
`define UBM_OFF_RXBUF   16'hFF92
`define UBM_OFF_TXBUF   16'hFF93
`define UBM_OFF_DIR     16'hFF94
`define UBM_OFF_TXSTAT  16'hFF95

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define UBM_MODE_PWR    7
`define UBM_MODE_TXE    6
`define UBM_MODE_RXE    5
`define UBM_MODE_PS_HI  4
`define UBM_MODE_PS_LO  3
`define UBM_MODE_CL     2
`define UBM_MODE_SL     1
`define UBM_MODE_ISRM   0

// ----------------------------------------
// other fields
// ----------------------------------------
`define UBM_ERR_PE      2
`define UBM_ERR_FE      1
`define UBM_ERR_OVE     0
`define UBM_TXS_BF      1
`define UBM_TXS_SF      0
`define UBM_DIR_MSB     0

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define UBM_RST_MODE    8'h01
`define UBM_RST_BUF     8'hFF
`define UBM_PAR_NONE    2'h0
`define UBM_PAR_ZERO    2'h1
`define UBM_PAR_ODD     2'h2
`define UBM_PAR_EVEN    2'h3
`define UBM_MASK_LSB7   8'h7F
`define UBM_MASK_MSB7   8'hFE

`endif

// ---- bench/ubm_uart_monitor.sv ----
// port-level checker for the serial buffers and mode block
`timescale 1ns/10ps

module ubm_uart_monitor #(
	parameter int BASE_DIV  = 4,
	parameter int BIT_TICKS = 16
) (
	input wire        clock,
	input wire        rst_n,
	input wire [15:0] addr,
	input wire [7:0]  wdata,
	input wire        wr_en,
	input wire        rd_en,
	input wire [7:0]  rdata_q,
	input wire        serial_in_pin,
	input wire        serial_out_pin,
	input wire        transmit_complete_irq_q,
	input wire        receive_complete_irq_q,
	input wire        receive_error_irq_q
);
	localparam int BIT_CYC = 2 * BASE_DIV * BIT_TICKS;
	logic [7:0] run_q;
	logic       last_q;

	// --------------------------------
	// line run length
	// --------------------------------
	// saturates so a long idle never wraps into a short run
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_q  <= 8'hFF;
			last_q <= 1'b1;
		end else begin
			last_q <= serial_out_pin;
			if (serial_out_pin != last_q)
				run_q <= 8'h00;
			else if (run_q != 8'hFF)
				run_q <= run_q + 8'h01;
		end
	end

	// --------------------------------
	// properties
	// --------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_unmapped_rd;
		rd_en && (addr < 16'hFF90 || addr > 16'hFF95);
	endsequence
	sequence s_line_edge;
		serial_out_pin != last_q;
	endsequence

	rdata_idle_a: assert property (!$past(rd_en) |-> rdata_q == 8'h00)
		else $error("read data outside read answer cycle");
	unmapped_rd_a: assert property (s_unmapped_rd |=> rdata_q == 8'h00)
		else $error("unmapped read returned data");
	bit_len_a: assert property (s_line_edge |-> run_q >= BIT_CYC - 1)
		else $error("serial bit shorter than one bit time");
	stop_high_a: assert property (transmit_complete_irq_q |-> $past(serial_out_pin))
		else $error("frame ended without high stop");
	txc_pulse_a: assert property (transmit_complete_irq_q |=> !transmit_complete_irq_q)
		else $error("transmit complete longer than one cycle");
	rxc_pulse_a: assert property (receive_complete_irq_q |=> !receive_complete_irq_q)
		else $error("receive complete longer than one cycle");
	rxe_pulse_a: assert property (receive_error_irq_q |=> !receive_error_irq_q)
		else $error("receive error longer than one cycle");
	irq_excl_a: assert property (!(receive_complete_irq_q && receive_error_irq_q))
		else $error("both receive interrupts at once");
endmodule // ubm_uart_monitor

// ---- bench/ubm_peer.sv ----
// remote serial node: frame sender and line sampler
`timescale 1ns/10ps

module ubm_peer #(
	parameter int BIT_CYC = 8
) (
	input  wire  clock,
	input  wire  line_in,
	output logic line_out
);
	int          nb = 9;
	logic [10:0] got_q [$];

	initial line_out = 1'b1;

	// low start, then data, parity and stop positions; idles high after
	task send(input logic [10:0] f);
		int i;
		line_out <= 1'b0;
		repeat (BIT_CYC) @(posedge clock);
		for (i = 0; i < nb; i++) begin
			line_out <= f[i];
			repeat (BIT_CYC) @(posedge clock);
		end
		line_out <= 1'b1;
	endtask

	// stops at mid stop bit so a back-to-back start is not missed
	always @(negedge line_in) begin : rx_p
		int          i;
		logic [10:0] w;
		w = 11'h7FF;
		repeat (BIT_CYC / 2) @(posedge clock);
		for (i = 0; i < nb; i++) begin
			repeat (BIT_CYC) @(posedge clock);
			w[i] = line_in;
		end
		got_q.push_back(w);
	end
endmodule // ubm_peer

// ---- bench/test_ubm_uart_core.sv ----
// self-checking bench for the serial buffers and mode block
`timescale 1ns/10ps
`include "ubm_defs.vh"

module test_ubm_uart_core;
	localparam int BD = 1;
	localparam int BT = 4;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] addr  = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	wire  [7:0]  rdata_q;
	wire         sin, sout, txc, rxc, rxe;
	int          num_errors = 0;
	int          num_checks = 0;
	logic [4:0]  cfg_t [5] = '{5'h00, 5'h00, 5'h1E, 5'h14, 5'h0C};
	logic        dir_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
	logic [7:0]  dat_t [5] = '{8'hA5, 8'h3C, 8'h96, 8'h5A, 8'hC3};

	always #5 clock = ~clock;

	ubm_uart_core #(.BASE_DIV(BD), .BIT_TICKS(BT)) dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .serial_in_pin(sin),
		.serial_out_pin(sout), .transmit_complete_irq_q(txc), .receive_complete_irq_q(rxc),
		.receive_error_irq_q(rxe));
	ubm_peer #(.BIT_CYC(2 * BD * BT)) peer_u (.clock(clock), .line_in(sout), .line_out(sin));

	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [10:0] frame(input int c, input logic [7:0] d);
		logic [10:0] f;
		int          i, n;
		logic        p;
		f = 11'h7FF;
		n = cfg_t[c][2] ? 8 : 7;
		p = 1'b0;
		for (i = 0; i < n; i++) begin
			f[i] = dir_t[c] ? d[7 - i] : d[i];
			p = p ^ f[i];
		end
		if (cfg_t[c][4:3] == `UBM_PAR_ZERO) f[n] = 1'b0;
		if (cfg_t[c][4:3] == `UBM_PAR_ODD) f[n] = ~p;
		if (cfg_t[c][4:3] == `UBM_PAR_EVEN) f[n] = p;
		return f;
	endfunction
	function automatic logic [7:0] rxexp(input int c, input logic [7:0] d);
		return cfg_t[c][2] ? d : (dir_t[c] ? d & `UBM_MASK_MSB7 : d & `UBM_MASK_LSB7);
	endfunction
	task chk(input logic [10:0] s, input logic [10:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		v = rdata_q;
	endtask
	task rdc(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	task wait_irq(input logic tx);
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while ((tx ? txc : (rxc | rxe)) !== 1'b1 && k < 500);
		chk(k < 500, 1'b1);
		@(negedge clock);
	endtask
	task final_report;
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task t_regs;
		rdc(`UBM_OFF_MODE, `UBM_RST_MODE);
		rdc(`UBM_OFF_RXBUF, `UBM_RST_BUF);
		rdc(`UBM_OFF_TXBUF, `UBM_RST_BUF);
		wr(`UBM_OFF_RXBUF, 8'h00);
		rdc(`UBM_OFF_RXBUF, `UBM_RST_BUF);
		rdc(16'hFFA0, 8'h00);
		wr(`UBM_OFF_MODE, 8'h5E);
		rdc(`UBM_OFF_MODE, 8'h5E);
	endtask
	// enables drop before the format fields change, then a base-clock wait before use
	task setup(input int c);
		wr(`UBM_OFF_MODE, 8'h80);
		wr(`UBM_OFF_MODE, {3'b100, cfg_t[c]});
		wr(`UBM_OFF_DIR, {7'h00, dir_t[c]});
		repeat (8) @(posedge clock);
		wr(`UBM_OFF_MODE, {3'b111, cfg_t[c]});
		repeat (8) @(posedge clock);
		peer_u.nb = (cfg_t[c][2] ? 8 : 7) + (cfg_t[c][4:3] != 2'h0) + 1;
	endtask
	task t_tx(input int c);
		logic [7:0] d, v;
		int         k;
		d = dat_t[c];
		peer_u.got_q.delete();
		wr(`UBM_OFF_TXBUF, d);
		wr(`UBM_OFF_MODE, {3'b111, cfg_t[c]});
		rdc(`UBM_OFF_TXBUF, d);
		k = 0;
		rd(`UBM_OFF_TXSTAT, v);
		while (v[1] !== 1'b0 && k < 100) begin
			rd(`UBM_OFF_TXSTAT, v);
			k++;
		end
		wr(`UBM_OFF_TXBUF, ~d);
		wait_irq(1'b1);
		wait_irq(1'b1);
		chk(peer_u.got_q.size(), 2);
		chk(peer_u.got_q[0], frame(c, d));
		chk(peer_u.got_q[1], frame(c, ~d));
	endtask
	task t_rx(input int c);
		fork
			peer_u.send(frame(c, dat_t[c]));
			wait_irq(1'b0);
		join
		rdc(`UBM_OFF_ERR, 8'h00);
		rdc(`UBM_OFF_RXBUF, rxexp(c, dat_t[c]));
	endtask
	// parity and stop both flipped: both flags set, data still kept
	task t_perr(input int c);
		fork
			peer_u.send(frame(c, dat_t[c]) ^ 11'h300);
			wait_irq(1'b0);
		join
		rdc(`UBM_OFF_ERR, 8'h06);
		rdc(`UBM_OFF_RXBUF, rxexp(c, dat_t[c]));
	endtask
	task t_ovr;
		fork
			peer_u.send(frame(4, 8'h11));
			wait_irq(1'b0);
		join
		fork
			peer_u.send(frame(4, 8'h22));
			wait_irq(1'b0);
		join
		rdc(`UBM_OFF_ERR, 8'h01);
		rdc(`UBM_OFF_RXBUF, 8'h11);
	endtask
	// power drops mid-frame with a second character waiting
	task t_pwr;
		wr(`UBM_OFF_TXBUF, 8'h00);
		repeat (4) @(posedge clock);
		wr(`UBM_OFF_TXBUF, 8'h0F);
		rdc(`UBM_OFF_TXSTAT, 8'h03);
		chk(sout, 1'b0);
		wr(`UBM_OFF_MODE, 8'h00);
		repeat (4) @(posedge clock);
		chk(sout, 1'b1);
		rdc(`UBM_OFF_RXBUF, `UBM_RST_BUF);
		rdc(`UBM_OFF_TXSTAT, 8'h00);
	endtask

	// --------------------------------
	// sequence and watchdog
	// --------------------------------
	initial begin : main_p
		int c;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		for (c = 0; c < 5; c++) begin
			setup(c);
			t_tx(c);
			t_rx(c);
			if (cfg_t[c][4])
				t_perr(c);
		end
		t_ovr;
		t_pwr;
		final_report;
	end
	// about five times the expected run
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
endmodule // test_ubm_uart_core

bind ubm_uart_core ubm_uart_monitor #(.BASE_DIV(BASE_DIV), .BIT_TICKS(BIT_TICKS)) mon_u (.clock(clock),
	.rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
	.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
	.transmit_complete_irq_q(transmit_complete_irq_q), .receive_complete_irq_q(receive_complete_irq_q),
	.receive_error_irq_q(receive_error_irq_q));
